// >>> stap_cfg.svh
/*
  stap_cfg.svh: constants of the sram test access port.
  assumes: included by its bare name, before the package and the core.
*/
`ifndef STAP_CFG_SVH
`define STAP_CFG_SVH

// instruction register width and codes
`define STAP_IR_W       3
`define STAP_IR_EXTEST  3'h0
`define STAP_IR_IDCODE  3'h1
`define STAP_IR_BYPASS  3'h7
// fixed pattern loaded into the low bits on capture-ir
`define STAP_IR_CAPT    2'h1
// identification register width and value (value arbitrary)
`define STAP_ID_W       32
`define STAP_ID_VALUE   32'h0A5A_5001
// consecutive tms ones that force test-logic-reset
`define STAP_TLR_ONES   3'h5

`endif

// >>> stap_ctl_model.sv
/*
  stap_ctl_model: tester model driving the test pins of the port.
  assumes: one caller at a time; tck stands low between steps.
*/
`timescale 1ns/10ps
`default_nettype none

module stap_ctl_model
  import stap_pkg::*;
(
  output var logic          tck,
  output var stap_pins_type pins,
  input  wire stap_tdo_type tdo_pin
);
  int   glitch_count;
  logic tms_on;
  logic tdi_on;

  ////////////////////////////////////////////////////////////////////
  // idle pins: tck stands still outside frames
  initial begin
    tck          = 1'b0;
    pins         = 4'b1111;
    glitch_count = 0;
    tms_on       = 1'b1;
    tdi_on       = 1'b1;
  end

  task automatic set_drive(input logic tms_drv, input logic tdi_drv);
    tms_on = tms_drv;
    tdi_on = tdi_drv;
  endtask : set_drive

  // one tck period
  // a floating pin toggles so a stale level never passes for a one
  task automatic step(input logic tms_v, input logic tdi_v, output stap_tdo_type seen);
    stap_tdo_type pre;
    pins.tms        = tms_on ? tms_v : ~pins.tms;
    pins.tms_driven = tms_on;
    pins.tdi        = tdi_on ? tdi_v : ~pins.tdi;
    pins.tdi_driven = tdi_on;
    #3.75;
    pre = tdo_pin;
    tck = 1'b1;
    #1;
    if (tdo_pin !== pre) glitch_count++; // tdo must hold across the rise
    #2.75;
    tck = 1'b0;
    #3.75;
    seen = tdo_pin;
    #3.75;
  endtask : step

  task automatic reset_seq(output stap_tdo_type seen);
    repeat (5) step(1'b1, 1'b1, seen);
  endtask : reset_seq
endmodule : stap_ctl_model
`default_nettype wire

// >>> stap_pkg.sv
/*
  stap_pkg: types of the sram test access port.
  assumes: nothing beyond a systemverilog compiler.
*/
package stap_pkg;

  // one-hot controller states
  typedef enum logic [15:0] {
    ST_TLR  = 16'h0001,
    ST_RTI  = 16'h0002,
    ST_SDRS = 16'h0004,
    ST_CDR  = 16'h0008,
    ST_SDR  = 16'h0010,
    ST_E1DR = 16'h0020,
    ST_PDR  = 16'h0040,
    ST_E2DR = 16'h0080,
    ST_UDR  = 16'h0100,
    ST_SIRS = 16'h0200,
    ST_CIR  = 16'h0400,
    ST_SIR  = 16'h0800,
    ST_E1IR = 16'h1000,
    ST_PIR  = 16'h2000,
    ST_E2IR = 16'h4000,
    ST_UIR  = 16'h8000
  } stap_state_type;

  // test pins into the port; driven flags come from the pad keepers
  typedef struct packed {
    logic tms;
    logic tms_driven;
    logic tdi;
    logic tdi_driven;
  } stap_pins_type;

  // serial output pin as data and enable
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } stap_tdo_type;

endpackage : stap_pkg

// >>> stap_tap.sv
/*
  stap_tap: boundary-scan test access port of a synchronous sram.
  assumes: tck is the tester's clock, unrelated to clock; pads
  report whether tms and tdi are driven; the tester resolves tdo
  from data and enable.
*/
`timescale 1ns/10ps
`default_nettype none
`include "stap_cfg.svh"


module stap_tap
  import stap_pkg::*;
#(
  parameter logic [`STAP_ID_W-1:0] ID_VALUE = `STAP_ID_VALUE
)(
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic          tck,
  input  wire stap_pins_type pins,
  output var  stap_tdo_type  tdo_pin,
  output logic               tap_busy
);

  // the standard wants a one in the id's lowest bit
  if (ID_VALUE[0] != 1'b1) begin : g_bad_id
    $error("stap_tap: ID_VALUE bit 0 must be one");
  end

  //////////////////////////////////////////////////////////////////
  // declarations

  logic                  por_hold;
  logic                  rst_meta;
  logic                  tap_rst;
  logic                  tms_eff;
  logic                  tdi_eff;
  stap_state_type        state;
  stap_state_type        next_state;
  logic [`STAP_IR_W-1:0] ir_shift;
  logic [`STAP_IR_W-1:0] ir;
  logic [`STAP_ID_W-1:0] id_shift;
  logic                  bypass;
  logic                  sel_id;
  logic                  tap_active;
  logic                  busy_meta;
  logic [2:0]            ones_cnt;

  //////////////////////////////////////////////////////////////////
  // power-up reset into the tck domain

  // system reset only
  // no test reset pin; power-up reset is the system reset, held
  // one clock so the tck side sees a clean level
  always_ff @(posedge clock) begin
    por_hold <= reset;
  end

  // asynchronous assert
  // asserts with no tck at all, releases after two tck rises
  always_ff @(posedge tck or posedge por_hold) begin
    if (por_hold) begin
      rst_meta <= 1'b1;
      tap_rst  <= 1'b1;
    end else begin
      rst_meta <= 1'b0;
      tap_rst  <= rst_meta;
    end
  end

  //////////////////////////////////////////////////////////////////
  // pin levels

  assign tms_eff = pins.tms_driven ? pins.tms : 1'b1;
  assign tdi_eff = pins.tdi_driven ? pins.tdi : 1'b1;

  //////////////////////////////////////////////////////////////////
  // controller

  always_comb begin
    next_state = ST_TLR;
    case (state)
      ST_TLR:  next_state = tms_eff ? ST_TLR  : ST_RTI;
      ST_RTI:  next_state = tms_eff ? ST_SDRS : ST_RTI;
      ST_SDRS: next_state = tms_eff ? ST_SIRS : ST_CDR;
      ST_CDR:  next_state = tms_eff ? ST_E1DR : ST_SDR;
      ST_SDR:  next_state = tms_eff ? ST_E1DR : ST_SDR;
      ST_E1DR: next_state = tms_eff ? ST_UDR  : ST_PDR;
      ST_PDR:  next_state = tms_eff ? ST_E2DR : ST_PDR;
      ST_E2DR: next_state = tms_eff ? ST_UDR  : ST_SDR;
      ST_UDR:  next_state = tms_eff ? ST_SDRS : ST_RTI;
      ST_SIRS: next_state = tms_eff ? ST_TLR  : ST_CIR;
      ST_CIR:  next_state = tms_eff ? ST_E1IR : ST_SIR;
      ST_SIR:  next_state = tms_eff ? ST_E1IR : ST_SIR;
      ST_E1IR: next_state = tms_eff ? ST_UIR  : ST_PIR;
      ST_PIR:  next_state = tms_eff ? ST_E2IR : ST_PIR;
      ST_E2IR: next_state = tms_eff ? ST_UIR  : ST_SIR;
      ST_UIR:  next_state = tms_eff ? ST_SDRS : ST_RTI;
      default: next_state = ST_TLR;
    endcase
  end

  always_ff @(posedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      state <= ST_TLR;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////
  // instruction register

  // capture loads 01
  // upper bit captures zero; it carries no status here
  always_ff @(posedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      ir_shift <= `STAP_IR_IDCODE;
    end else if (state == ST_CIR) begin
      ir_shift <= {1'b0, `STAP_IR_CAPT};
    end else if (state == ST_SIR) begin
      ir_shift <= {tdi_eff, ir_shift[`STAP_IR_W-1:1]};
    end
  end

  always_ff @(posedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      ir <= `STAP_IR_IDCODE;
    end else if (state == ST_TLR) begin
      ir <= `STAP_IR_IDCODE;
    end else if (state == ST_UIR) begin
      ir <= ir_shift;
    end
  end

  // instruction picks register
  // codes other than idcode fall back to bypass: there is no
  // boundary chain in this port, so the scan path stays short
  assign sel_id = (ir == `STAP_IR_IDCODE);

  //////////////////////////////////////////////////////////////////
  // data registers

  always_ff @(posedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      id_shift <= ID_VALUE;
    end else if (sel_id && state == ST_CDR) begin
      id_shift <= ID_VALUE;
    end else if (sel_id && state == ST_SDR) begin
      id_shift <= {tdi_eff, id_shift[`STAP_ID_W-1:1]};
    end
  end

  // one-bit bypass
  // capture clears it, as the standard asks
  always_ff @(posedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      bypass <= 1'b0;
    end else if (!sel_id && state == ST_CDR) begin
      bypass <= 1'b0;
    end else if (!sel_id && state == ST_SDR) begin
      bypass <= tdi_eff;
    end
  end

  //////////////////////////////////////////////////////////////////
  // serial output on the falling edge

  always_ff @(negedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      tdo_pin.tdo <= 1'b0;
    end else if (state == ST_SIR) begin
      tdo_pin.tdo <= ir_shift[0];
    end else if (state == ST_SDR) begin
      tdo_pin.tdo <= sel_id ? id_shift[0] : bypass;
    end else begin
      tdo_pin.tdo <= 1'b0;
    end
  end

  always_ff @(negedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      tdo_pin.tdo_oe <= 1'b0;
    end else begin
      tdo_pin.tdo_oe <= (state == ST_SIR) || (state == ST_SDR);
    end
  end

  //////////////////////////////////////////////////////////////////
  // activity seen from the memory clock

  // inactive until clocked
  // stays low from power-up until tms walks out of reset; follows the
  // next state so the flag settles even when tck stops right after
  always_ff @(posedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      tap_active <= 1'b0;
    end else begin
      tap_active <= (next_state != ST_TLR);
    end
  end

  // two-flop crossing of a slow level into the memory clock
  always_ff @(posedge clock) begin
    if (reset) begin
      busy_meta <= 1'b0;
      tap_busy  <= 1'b0;
    end else begin
      busy_meta <= tap_active;
      tap_busy  <= busy_meta;
    end
  end

  //////////////////////////////////////////////////////////////////
  // checks

  // helper: run of consecutive tms ones, saturating at five
  always_ff @(posedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      ones_cnt <= 3'h0;
    end else if (!tms_eff) begin
      ones_cnt <= 3'h0;
    end else if (ones_cnt != `STAP_TLR_ONES) begin
      ones_cnt <= ones_cnt + 3'h1;
    end
  end

  AST_FIVE_ONES_RESET: assert property (
    @(posedge tck) disable iff (tap_rst)
    (ones_cnt == `STAP_TLR_ONES) |-> (state == ST_TLR))
    else $error("five tms ones did not reach reset");

  AST_TMS_STEERS: assert property (
    @(posedge tck) disable iff (tap_rst)
    (state == ST_SDR) |=>
      (state == ($past(tms_eff) ? ST_E1DR : ST_SDR)))
    else $error("shift-dr left against tms");

  AST_ONE_HOT: assert property (
    @(posedge tck) disable iff (tap_rst)
    $onehot(state))
    else $error("controller state not one-hot");

  AST_TLR_IDCODE: assert property (
    @(posedge tck) disable iff (tap_rst)
    (state == ST_TLR) |=> (ir == `STAP_IR_IDCODE))
    else $error("reset did not load idcode");

  AST_CAPTURE_IR: assert property (
    @(posedge tck) disable iff (tap_rst)
    (state == ST_CIR) |=>
      (ir_shift[1:0] == `STAP_IR_CAPT) && $stable(ir))
    else $error("capture-ir pattern wrong or ir moved");

  AST_UPDATE_IR: assert property (
    @(posedge tck) disable iff (tap_rst)
    (state == ST_UIR) |=> (ir == $past(ir_shift)))
    else $error("update-ir did not apply the instruction");

  AST_TDO_ENABLE: assert property (
    @(posedge tck) disable iff (tap_rst)
    tdo_pin.tdo_oe == ((state == ST_SIR) || (state == ST_SDR)))
    else $error("tdo enable outside shift states");

  AST_BYPASS_PATH: assert property (
    @(posedge tck) disable iff (tap_rst)
    (state == ST_SDR && !sel_id && !tms_eff) |=>
      (tdo_pin.tdo == $past(tdi_eff)))
    else $error("bypass did not pass tdi in one bit");

  AST_ID_CAPTURE: assert property (
    @(posedge tck) disable iff (tap_rst)
    (state == ST_CDR && sel_id && !tms_eff) |=>
      (id_shift == ID_VALUE) && (tdo_pin.tdo == ID_VALUE[0]))
    else $error("id capture or first bit wrong");

  AST_IDLE_QUIET: assert property (
    @(posedge tck) disable iff (tap_rst)
    (state == ST_TLR) ##1 (state == ST_TLR) |-> !tap_active)
    else $error("port active while held in reset");

  AST_ACTIVE_TRACKS: assert property (
    @(posedge tck) disable iff (tap_rst)
    tap_active == (state != ST_TLR))
    else $error("activity flag does not follow the controller");

  AST_IR_SHIFT_OUT: assert property (
    @(posedge tck) disable iff (tap_rst)
    (state == ST_SIR) |-> (tdo_pin.tdo == ir_shift[0]))
    else $error("instruction bit missing from tdo");

  COV_ID_SHIFT: cover property (
    @(posedge tck) disable iff (tap_rst)
    (state == ST_CDR && sel_id) ##1 (state == ST_SDR)[*4]);

  COV_UPDATE_IR: cover property (
    @(posedge tck) disable iff (tap_rst)
    (state == ST_SIR) ##1 (state == ST_E1IR) ##1 (state == ST_UIR));

  COV_BYPASS: cover property (
    @(posedge tck) disable iff (tap_rst)
    (state == ST_SDR && !sel_id)[*3]);

  COV_FIVE_ONES: cover property (
    @(posedge tck) disable iff (tap_rst)
    (state == ST_SDR && tms_eff) ##1 tms_eff[*4] ##1 (state == ST_TLR));

endmodule : stap_tap

`default_nettype wire

// >>> testbench.sv
/*
  testbench: self-checking bench of the sram test access port.
  assumes: stap_tap and stap_ctl_model compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "stap_cfg.svh"

module testbench;
  import stap_pkg::*;
  localparam logic [31:0] ID_EXP = `STAP_ID_VALUE;
  logic          clock;
  logic          reset;
  logic          tck;
  stap_pins_type pins;
  stap_tdo_type  tdo_pin;
  logic          tap_busy;
  stap_tdo_type  seen;
  int            err_count = 0;
  int            total_checks = 0;
  int            cycles = 0;

  stap_tap i_dut (.clock(clock), .reset(reset), .tck(tck), .pins(pins),
                  .tdo_pin(tdo_pin), .tap_busy(tap_busy));
  stap_ctl_model i_ctl (.tck(tck), .pins(pins), .tdo_pin(tdo_pin));

  ////////////////////////////////////////////////////////////////////
  // memory clock, 20 ns
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // hang guard, far above the two hundred or so cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : wait_clk

  // n tck steps, tms taken lsb first, tdi low
  task automatic walk(input logic [7:0] tms_bits, input int n);
    for (int i = 0; i < n; i++) i_ctl.step(tms_bits[i], 1'b0, seen);
  endtask : walk

  ////////////////////////////////////////////////////////////////////
  // port silent after reset while tck is still idle
  task automatic t_power_up();
    check("tdo idle", 32'(tdo_pin), 32'h0);
    wait_clk(30);
    check("busy idle", 32'(tap_busy), 32'h0);
    check("tdo still idle", 32'(tdo_pin), 32'h0);
  endtask : t_power_up

  // from idle: capture-dr, 32 bits out, back to idle
  task automatic t_read_id();
    logic [31:0] got;
    logic        oe_all;
    walk(8'h01, 3);
    got[0] = seen.tdo;
    oe_all = seen.tdo_oe;
    for (int i = 1; i < 32; i++) begin
      i_ctl.step(1'b0, 1'b0, seen);
      got[i] = seen.tdo;
      oe_all = oe_all & seen.tdo_oe;
    end
    i_ctl.step(1'b1, 1'b0, seen);
    check("id value", got, ID_EXP);
    check("oe in shift", 32'(oe_all), 32'h1);
    check("oe after exit", 32'(seen), 32'h0);
    walk(8'h01, 2);
  endtask : t_read_id

  // from idle: shift an instruction in, captured bits out
  task automatic t_load_ir(input logic [2:0] code);
    logic [2:0] cap;
    walk(8'h03, 4);
    cap[0] = seen.tdo;
    i_ctl.step(1'b0, code[0], seen);
    cap[1] = seen.tdo;
    i_ctl.step(1'b0, code[1], seen);
    cap[2] = seen.tdo;
    i_ctl.step(1'b1, code[2], seen);
    check("ir capture", 32'(cap), 32'(`STAP_IR_CAPT));
    walk(8'h01, 2);
  endtask : t_load_ir

  // one-bit path; floating tdi shifts ones
  task automatic t_bypass(input logic [2:0] code);
    logic [7:0] pat;
    pat = 8'hB4 ^ {5'h0, code};
    t_load_ir(code);
    walk(8'h01, 3);
    check("bypass capture", 32'(seen.tdo), 32'h0);
    for (int i = 0; i < 8; i++) begin
      i_ctl.step(1'b0, pat[i], seen);
      check("bypass bit", 32'(seen.tdo), 32'(pat[i]));
    end
    i_ctl.set_drive(1'b1, 1'b0);
    walk(8'h00, 2);
    check("floating tdi", 32'(seen.tdo), 32'h1);
    i_ctl.set_drive(1'b1, 1'b1);
    walk(8'h03, 3);
  endtask : t_bypass

  // floating tms from shift-dr returns to reset and the id instruction
  task automatic t_tlr();
    walk(8'h01, 3);
    i_ctl.set_drive(1'b0, 1'b1);
    walk(8'h00, 5);
    check("tdo after reset walk", 32'(seen), 32'h0);
    wait_clk(10);
    check("busy after reset walk", 32'(tap_busy), 32'h0);
    i_ctl.set_drive(1'b1, 1'b1);
    walk(8'h00, 1);
    wait_clk(10);
    check("busy in idle", 32'(tap_busy), 32'h1);
    t_read_id();
  endtask : t_tlr

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset = 1'b1;
    wait_clk(20);
    reset = 1'b0;
    t_power_up();
    i_ctl.reset_seq(seen);
    walk(8'h00, 1);
    t_read_id();
    t_bypass(`STAP_IR_BYPASS);
    t_bypass(`STAP_IR_EXTEST);
    t_bypass(3'h5);
    t_tlr();
    check("tdo moved at rise", 32'(i_ctl.glitch_count), 32'h0);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
